/* File: pkg/status_pkg.sv */
// package: register selectors, field positions, widths and reset values of the status reporting block
package status_pkg;
    localparam int GROUP_W = 16;
    localparam int BYTE_W  = 8;

    // register selectors on the register port
    localparam logic [3:0] SEL_OPERATION_SUMMARY_COND   = 4'h0;
    localparam logic [3:0] SEL_OPERATION_SUMMARY_RISE   = 4'h1;
    localparam logic [3:0] SEL_OPERATION_SUMMARY_FALL   = 4'h2;
    localparam logic [3:0] SEL_OPERATION_SUMMARY_EVENT  = 4'h3;
    localparam logic [3:0] SEL_OPERATION_SUMMARY_ENABLE = 4'h4;
    localparam logic [3:0] SEL_FAULT_COND  = 4'h5;
    localparam logic [3:0] SEL_FAULT_RISE  = 4'h6;
    localparam logic [3:0] SEL_FAULT_FALL  = 4'h7;
    localparam logic [3:0] SEL_FAULT_EVENT = 4'h8;
    localparam logic [3:0] SEL_FAULT_EN    = 4'h9;
    localparam logic [3:0] SEL_STD_EVENT   = 4'hA;
    localparam logic [3:0] SEL_STD_ENABLE  = 4'hB;
    localparam logic [3:0] SEL_STATUS_BYTE = 4'hC;
    localparam logic [3:0] SEL_SRQ_ENABLE  = 4'hD;

    // operation condition bits
    localparam int OPERATION_SUMMARY_CAL_BIT  = 0;
    localparam int OPERATION_SUMMARY_WAIT_BIT = 5;
    localparam int OPERATION_SUMMARY_VOLT_BIT = 8;
    localparam int OPERATION_SUMMARY_CCP_BIT  = 10;
    localparam int OPERATION_SUMMARY_CCN_BIT  = 11;

    // fault condition bits
    localparam int FAULT_VOLT_BIT  = 0;
    localparam int FAULT_OC_BIT    = 1;
    localparam int FAULT_FUSE_BIT  = 2;
    localparam int FAULT_TEMP_BIT  = 4;
    localparam int FAULT_REMOTE_BIT = 9;
    localparam int FAULT_UNREG_BIT = 10;
    localparam int FAULT_OVLD_BIT  = 14;

    // standard event bits
    localparam int STD_OPC_BIT = 0;
    localparam int STD_QYE_BIT = 2;
    localparam int STD_DDE_BIT = 3;
    localparam int STD_EXE_BIT = 4;
    localparam int STD_CME_BIT = 5;
    localparam int STD_PON_BIT = 7;

    // status byte bits
    localparam int SB_FAULT_BIT = 3;
    localparam int SB_MAV_BIT   = 4;
    localparam int SB_ESB_BIT   = 5;
    localparam int SB_MSS_BIT   = 6;
    localparam int SB_OPERATION_SUMMARY_BIT  = 7;

    // reset values
    localparam logic [15:0] GROUP_RESET = 16'h0000;
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [7:0]  PON_EVENT   = 8'h80;
endpackage

/* File: verif/bus_controller_model.sv */
// controller model: register accesses and serial polls toward the status block
`timescale 1ns/1ps
module bus_controller_model (
    input  wire logic        clock,
    input  wire logic [15:0] regReadData,
    input  wire logic        regReadValid,
    input  wire logic [7:0]  pollData,
    input  wire logic        pollValid,
    output logic      [3:0]  regSelect,
    output logic             regWrite,
    output logic             regRead,
    output logic      [15:0] regWriteData,
    output logic             serialPoll
);
    // idle: strobes low, qualifiers parked
    initial
    begin
        {regWrite, regRead, serialPoll} = 3'b000;
        {regSelect, regWriteData} = 20'h0_0000;
    end
    // one-cycle strobe; qualifiers inverted on release so a late sample shows
    task automatic acc(input logic w, input logic [3:0] s, input logic [15:0] d, output logic [15:0] q);
        @(posedge clock);
        #1;
        {regWrite, regRead, regSelect, regWriteData} = {w, !w, s, d};
        @(posedge clock);
        #1;
        {regWrite, regRead, regSelect, regWriteData} = {2'b00, ~s, ~d};
        q = (!w && regReadValid === 1'b1) ? regReadData : 16'hxxxx;
    endtask
    // answer is due one cycle after the poll edge
    task automatic poll(output logic [7:0] q);
        @(posedge clock);
        #1;
        serialPoll = 1'b1;
        @(posedge clock);
        #1;
        serialPoll = 1'b0;
        q = pollValid === 1'b1 ? pollData : 8'hxx;
    endtask
endmodule

/* File: verif/status_reporting_asserts.sv */
// checker: register port, poll and standard enable timing of the status block
`timescale 1ns/1ps
module status_reporting_asserts (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        clockEnable,
    input wire logic [3:0]  regSelect,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic        serialPoll,
    input wire logic [15:0] regReadData,
    input wire logic        regReadValid,
    input wire logic [7:0]  pollData,
    input wire logic        pollValid,
    input wire logic        serviceRequest,
    input wire logic [7:0]  stdEnableOut
);
    import status_pkg::*;
    logic up;
    wire  stdWr = clockEnable && regWrite && regSelect == SEL_STD_ENABLE;
    // set once the power-up load of the standard enable is behind us
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            up <= 1'b0;
        else if (clockEnable)
            up <= 1'b1;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // port timing, status byte layout, poll answer and enable hold
    property p_rd_ans; clockEnable && regRead |=> regReadValid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rd_cause; regReadValid |-> $past(regRead); endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("answer without read");
    property p_poll_ans; clockEnable && serialPoll |=> pollValid; endproperty
    a_poll_ans: assert property (p_poll_ans) else $error("poll not answered");
    property p_poll_cause; pollValid |-> $past(serialPoll); endproperty
    a_poll_cause: assert property (p_poll_cause) else $error("poll answer without poll");
    property p_poll_low; pollValid |-> pollData[2:0] == 3'b000; endproperty
    a_poll_low: assert property (p_poll_low) else $error("unused poll bits set");
    property p_stb_bits; regReadValid && $past(regSelect) == SEL_STATUS_BYTE
        |-> regReadData[15:8] == 8'h00 && regReadData[2:0] == 3'b000; endproperty
    a_stb_bits: assert property (p_stb_bits) else $error("unused status bits set");
    property p_poll_rqs; clockEnable && serialPoll && serviceRequest && !pollValid |=> pollData[6]; endproperty
    a_poll_rqs: assert property (p_poll_rqs) else $error("request bit lost in poll");
    // the mirror lags the enable by one flop, so a write shows two edges later
    property p_std_hold; up && !stdWr |=> ##1 $stable(stdEnableOut); endproperty
    a_std_hold: assert property (p_std_hold) else $error("enable changed without write");
endmodule

/* File: verif/testbench.sv */
// testbench: status groups, summaries, service request and power-up behaviour
`timescale 1ns/1ps
module testbench;
    import status_pkg::*;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        poweron_status_clear = 1'b0;
    logic        queueNotEmpty = 1'b0;
    logic [15:0] opCond = 16'h0000;
    logic [15:0] faultCond = 16'h0000;
    logic [7:0]  stdPulse = 8'h00;
    logic [15:0] regWriteData, regReadData, v;
    logic [7:0]  pollData, stdEnableOut, pv;
    logic [3:0]  regSelect;
    logic        regWrite, regRead, serialPoll, regReadValid, pollValid, serviceRequest;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cycles = 0;
    int          opBits[] = '{0, 5, 8, 10, 11};
    int          faultBits[] = '{0, 1, 2, 4, 9, 10, 14};
    // clock, and a ceiling well above the expected few hundred cycles
    initial
        forever #5 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end
    status_reporting_model dut (.clock, .resetn, .clockEnable(1'b1), .queueNotEmpty, .poweron_status_clear,
        .calibrating(opCond[0]), .trigger_wait_flag(opCond[5]), .const_voltage_flag(opCond[8]),
        .const_current_pos_flag(opCond[10]), .const_current_neg_flag(opCond[11]),
        .overvoltage_trip(faultCond[0]), .overcurrent_trip(faultCond[1]), .fuse_blown(faultCond[2]),
        .overtemp_trip(faultCond[4]), .remote_inhibit_active(faultCond[9]), .unregulated(faultCond[10]),
        .low_range_overload(faultCond[14]), .opCompleteEvent(stdPulse[0]), .queryErrorEvent(stdPulse[2]),
        .deviceErrorEvent(stdPulse[3]), .execErrorEvent(stdPulse[4]), .commandErrorEvent(stdPulse[5]),
        .retainedStdEnable(8'h80), .regSelect, .regWrite, .regRead, .regWriteData, .serialPoll,
        .regReadData, .regReadValid, .pollData, .pollValid, .serviceRequest, .stdEnableOut);
    bus_controller_model ctrl (.clock, .regReadData, .regReadValid, .pollData, .pollValid,
        .regSelect, .regWrite, .regRead, .regWriteData, .serialPoll);
    // shared comparison, access and stimulus helpers
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] s, input logic [15:0] d);
        ctrl.acc(1'b1, s, d, v);
    endtask
    task automatic rdck(input logic [3:0] s, input logic [15:0] e);
        ctrl.acc(1'b0, s, 16'h0000, v);
        check(v, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic pulse(input logic [7:0] p);
        settle(1);
        stdPulse = p;
        settle(1);
        stdPulse = 8'h00;
    endtask
    task automatic drive(input logic isOp, input logic [15:0] m);
        if (isOp)
            opCond = m;
        else
            faultCond = m;
        settle(6);
    endtask
    task automatic doReset(input logic clr);
        poweron_status_clear = clr;
        resetn = 1'b0;
        settle(10);
        resetn = 1'b1;
        // power-up load at the first edge, mirror output at the second
        settle(2);
    endtask
    // each bit passed by the rise filter alone, then by the fall filter alone
    task automatic groupTest(input logic [3:0] cs, input int bits[], input logic isOp);
        logic [15:0] m;
        for (int p = 0; p < 2; p++)
        begin
            wr(cs + 4'h1, p == 0 ? 16'hffff : 16'h0000);
            wr(cs + 4'h2, p == 0 ? 16'h0000 : 16'hffff);
            foreach (bits[i])
            begin
                m = 16'h0001 << bits[i];
                drive(isOp, m);
                rdck(cs, m);
                rdck(cs + 4'h3, p == 0 ? m : 16'h0000);
                rdck(cs + 4'h3, 16'h0000);
                drive(isOp, 16'h0000);
                rdck(cs + 4'h3, p == 0 ? 16'h0000 : m);
            end
        end
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // main sequence
    initial
    begin
        doReset(1'b0);
        check({8'h00, stdEnableOut}, 16'h0080);
        wr(SEL_OPERATION_SUMMARY_COND, 16'hffff);
        rdck(SEL_OPERATION_SUMMARY_COND, 16'h0000);
        rdck(4'hF, 16'h0000);
        wr(SEL_SRQ_ENABLE, 16'h0020);
        rdck(SEL_SRQ_ENABLE, 16'h0020);
        settle(3);
        check({15'h0000, serviceRequest}, 16'h0001);
        ctrl.poll(pv);
        check({8'h00, pv}, 16'h0060);
        settle(2);
        check({15'h0000, serviceRequest}, 16'h0000);
        rdck(SEL_STATUS_BYTE, 16'h0060);
        rdck(SEL_STD_EVENT, 16'h0080);
        rdck(SEL_STD_EVENT, 16'h0000);
        rdck(SEL_STATUS_BYTE, 16'h0000);
        $display("test power-up request done");
        groupTest(SEL_OPERATION_SUMMARY_COND, opBits, 1'b1);
        groupTest(SEL_FAULT_COND, faultBits, 1'b0);
        $display("test transition filters done");
        wr(SEL_OPERATION_SUMMARY_ENABLE, 16'h0400);
        wr(SEL_FAULT_EN, 16'h0013);
        wr(SEL_OPERATION_SUMMARY_RISE, 16'hffff);
        wr(SEL_FAULT_RISE, 16'hffff);
        wr(SEL_SRQ_ENABLE, 16'h0088);
        opCond = 16'h0100;
        drive(1'b0, 16'h0004);
        rdck(SEL_STATUS_BYTE, 16'h0000);
        opCond = 16'h0500;
        queueNotEmpty = 1'b1;
        drive(1'b0, 16'h0014);
        rdck(SEL_STATUS_BYTE, 16'h00d8);
        check({15'h0000, serviceRequest}, 16'h0001);
        rdck(SEL_OPERATION_SUMMARY_EVENT, 16'h0500);
        rdck(SEL_STATUS_BYTE, 16'h0058);
        rdck(SEL_FAULT_EVENT, 16'h0014);
        rdck(SEL_STATUS_BYTE, 16'h0010);
        $display("test summaries done");
        pulse(8'h3d);
        rdck(SEL_STD_EVENT, 16'h003d);
        fork
            ctrl.acc(1'b0, SEL_STD_EVENT, 16'h0000, v);
            pulse(8'h10);
        join
        check(v, 16'h0000);
        wr(SEL_STD_ENABLE, 16'h0010);
        rdck(SEL_STATUS_BYTE, 16'h0030);
        rdck(SEL_STD_EVENT, 16'h0010);
        $display("test standard events done");
        doReset(1'b1);
        check({8'h00, stdEnableOut}, 16'h0000);
        rdck(SEL_STD_EVENT, 16'h0080);
        $display("test cleared power-up done");
        final_report();
    end
endmodule
bind status_reporting_model status_reporting_asserts chk (.clock, .resetn, .clockEnable, .regSelect,
    .regWrite, .regRead, .serialPoll, .regReadData, .regReadValid, .pollData, .pollValid,
    .serviceRequest, .stdEnableOut);

/* File: verilog/input_sync.sv */
// three-flop synchroniser with agreement check on the last two stages
`timescale 1ns/1ps
module input_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic             enable,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // first stage only feeds the second; a change counts once stages two and three agree
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            stage1  <= '0;
            stage2  <= '0;
            stage3  <= '0;
            syncOut <= '0;
        end
        else if (enable)
        begin
            stage1 <= asyncIn;
            stage2 <= stage1;
            stage3 <= stage2;
            for (int i = 0; i < WIDTH; i++)
            begin
                if (stage2[i] == stage3[i])
                    syncOut[i] <= stage3[i];
            end
        end
    end
endmodule

/* File: verilog/status_reporting_model.sv */
// status reporting model: operation, fault and standard event groups feeding the status byte
`timescale 1ns/1ps
module status_reporting_model (
    input  wire logic                           clock,
    input  wire logic                           resetn,
    input  wire logic                           clockEnable,
    // live monitored circuit states, from outside this clock domain
    input  wire logic                           calibrating,
    input  wire logic                           trigger_wait_flag,
    input  wire logic                           const_voltage_flag,
    input  wire logic                           const_current_pos_flag,
    input  wire logic                           const_current_neg_flag,
    input  wire logic                           overvoltage_trip,
    input  wire logic                           overcurrent_trip,
    input  wire logic                           fuse_blown,
    input  wire logic                           overtemp_trip,
    input  wire logic                           remote_inhibit_active,
    input  wire logic                           unregulated,
    input  wire logic                           low_range_overload,
    // communication events, one-cycle pulses from the command parser
    input  wire logic                           opCompleteEvent,
    input  wire logic                           queryErrorEvent,
    input  wire logic                           deviceErrorEvent,
    input  wire logic                           execErrorEvent,
    input  wire logic                           commandErrorEvent,
    // output queue occupancy
    input  wire logic                           queueNotEmpty,
    // clear-at-power-on setting and the retained standard enable across power cycles
    input  wire logic                           poweron_status_clear,
    input  wire logic [status_pkg::BYTE_W-1:0]  retainedStdEnable,
    // register port from the command parser
    input  wire logic [3:0]                     regSelect,
    input  wire logic                           regWrite,
    input  wire logic                           regRead,
    input  wire logic [status_pkg::GROUP_W-1:0] regWriteData,
    input  wire logic                           serialPoll,
    output logic      [status_pkg::GROUP_W-1:0] regReadData,
    output logic                                regReadValid,
    output logic      [status_pkg::BYTE_W-1:0]  pollData,
    output logic                                pollValid,
    output logic                                serviceRequest,
    output logic      [status_pkg::BYTE_W-1:0]  stdEnableOut
);
    import status_pkg::*;

    logic [GROUP_W-1:0] operRaw;
    logic [GROUP_W-1:0] faultRaw;
    logic [GROUP_W-1:0] operCondition;
    logic [GROUP_W-1:0] faultCondition;
    logic [GROUP_W-1:0] operRise;
    logic [GROUP_W-1:0] operFall;
    logic [GROUP_W-1:0] operEnable;
    logic [GROUP_W-1:0] faultRise;
    logic [GROUP_W-1:0] faultFall;
    logic [GROUP_W-1:0] faultEnable;
    logic [GROUP_W-1:0] operEvent;
    logic [GROUP_W-1:0] faultEvent;
    logic [GROUP_W-1:0] stdEventWide;
    logic [BYTE_W-1:0]  stdEvent;
    logic [BYTE_W-1:0]  stdEnable;
    logic [BYTE_W-1:0]  srqEnable;
    logic [BYTE_W-1:0]  stdSet;
    logic               operSummary;
    logic               faultSummary;
    logic               stdSummary;
    logic               masterSummary;
    logic               requestService;
    logic               powerUp;
    logic [BYTE_W-1:0]  statusByte;
    logic [BYTE_W-1:0]  pollByte;
    logic [GROUP_W-1:0] readMux;

    // condition vector layout
    always_comb
    begin
        operRaw                 = GROUP_RESET;
        operRaw[OPERATION_SUMMARY_CAL_BIT]   = calibrating;
        operRaw[OPERATION_SUMMARY_WAIT_BIT]  = trigger_wait_flag;
        operRaw[OPERATION_SUMMARY_VOLT_BIT]  = const_voltage_flag;
        operRaw[OPERATION_SUMMARY_CCP_BIT]   = const_current_pos_flag;
        operRaw[OPERATION_SUMMARY_CCN_BIT]   = const_current_neg_flag;
        faultRaw                 = GROUP_RESET;
        faultRaw[FAULT_VOLT_BIT] = overvoltage_trip;
        faultRaw[FAULT_OC_BIT]   = overcurrent_trip;
        faultRaw[FAULT_FUSE_BIT] = fuse_blown;
        faultRaw[FAULT_TEMP_BIT] = overtemp_trip;
        faultRaw[FAULT_REMOTE_BIT] = remote_inhibit_active;
        faultRaw[FAULT_UNREG_BIT]= unregulated;
        faultRaw[FAULT_OVLD_BIT] = low_range_overload;
    end

    // circuit states are asynchronous to the clock, so they are synchronised first
    input_sync #(.WIDTH(GROUP_W)) u_operSync (
        .clock   (clock),
        .resetn  (resetn),
        .enable  (clockEnable),
        .asyncIn (operRaw),
        .syncOut (operCondition)
    );

    input_sync #(.WIDTH(GROUP_W)) u_faultSync (
        .clock   (clock),
        .resetn  (resetn),
        .enable  (clockEnable),
        .asyncIn (faultRaw),
        .syncOut (faultCondition)
    );

    // register write and clearing-read decode
    wire writeOperRise   = regWrite && (regSelect == SEL_OPERATION_SUMMARY_RISE);
    wire writeOperFall   = regWrite && (regSelect == SEL_OPERATION_SUMMARY_FALL);
    wire writeOperEnable = regWrite && (regSelect == SEL_OPERATION_SUMMARY_ENABLE);
    wire writeFaultRise  = regWrite && (regSelect == SEL_FAULT_RISE);
    wire writeFaultFall  = regWrite && (regSelect == SEL_FAULT_FALL);
    wire writeFaultEn    = regWrite && (regSelect == SEL_FAULT_EN);
    wire writeStdEnable  = regWrite && (regSelect == SEL_STD_ENABLE);
    wire writeSrqEnable  = regWrite && (regSelect == SEL_SRQ_ENABLE);
    wire readOperEvent   = regRead && (regSelect == SEL_OPERATION_SUMMARY_EVENT);
    wire readFaultEvent  = regRead && (regSelect == SEL_FAULT_EVENT);
    wire readStdEvent    = regRead && (regSelect == SEL_STD_EVENT);

    // filter and enable masks; conditions and events have no write path
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            operRise    <= GROUP_RESET;
            operFall    <= GROUP_RESET;
            operEnable  <= GROUP_RESET;
            faultRise   <= GROUP_RESET;
            faultFall   <= GROUP_RESET;
            faultEnable <= GROUP_RESET;
            srqEnable   <= BYTE_RESET;
        end
        else if (clockEnable)
        begin
            if (writeOperRise)   operRise    <= regWriteData;
            if (writeOperFall)   operFall    <= regWriteData;
            if (writeOperEnable) operEnable  <= regWriteData;
            if (writeFaultRise)  faultRise   <= regWriteData;
            if (writeFaultFall)  faultFall   <= regWriteData;
            if (writeFaultEn)    faultEnable <= regWriteData;
            if (writeSrqEnable)  srqEnable   <= regWriteData[BYTE_W-1:0];
        end
    end

    // power-up marker: high for the first enabled cycle after reset release
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            powerUp <= 1'b1;
        else if (clockEnable)
            powerUp <= 1'b0;
    end

    // standard enable: a reset cannot load a port, so the retained value is taken at power-up
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            stdEnable <= BYTE_RESET;
        else if (clockEnable)
        begin
            if (powerUp)
                stdEnable <= poweron_status_clear ? BYTE_RESET : retainedStdEnable;
            else if (writeStdEnable)
                stdEnable <= regWriteData[BYTE_W-1:0];
        end
    end

    // communication events plus the power-on flag
    always_comb
    begin
        stdSet              = BYTE_RESET;
        stdSet[STD_OPC_BIT] = opCompleteEvent;
        stdSet[STD_QYE_BIT] = queryErrorEvent;
        stdSet[STD_DDE_BIT] = deviceErrorEvent;
        stdSet[STD_EXE_BIT] = execErrorEvent;
        stdSet[STD_CME_BIT] = commandErrorEvent;
        stdSet[STD_PON_BIT] = powerUp;
    end

    transition_filter #(.WIDTH(GROUP_W)) u_operGroup (
        .clock      (clock),
        .resetn     (resetn),
        .enable     (clockEnable),
        .condition  (operCondition),
        .riseFilter (operRise),
        .fallFilter (operFall),
        .enableMask (operEnable),
        .extraSet   (GROUP_RESET),
        .clearRead  (readOperEvent),
        .eventLatch (operEvent),
        .summary    (operSummary)
    );

    transition_filter #(.WIDTH(GROUP_W)) u_faultGroup (
        .clock      (clock),
        .resetn     (resetn),
        .enable     (clockEnable),
        .condition  (faultCondition),
        .riseFilter (faultRise),
        .fallFilter (faultFall),
        .enableMask (faultEnable),
        .extraSet   (GROUP_RESET),
        .clearRead  (readFaultEvent),
        .eventLatch (faultEvent),
        .summary    (faultSummary)
    );

    // standard events reuse the group latch with filters off and direct sets
    transition_filter #(.WIDTH(GROUP_W)) u_stdGroup (
        .clock      (clock),
        .resetn     (resetn),
        .enable     (clockEnable),
        .condition  (GROUP_RESET),
        .riseFilter (GROUP_RESET),
        .fallFilter (GROUP_RESET),
        .enableMask ({8'h00, stdEnable}),
        .extraSet   ({8'h00, stdSet}),
        .clearRead  (readStdEvent),
        .eventLatch (stdEventWide),
        .summary    (stdSummary)
    );
    assign stdEvent = stdEventWide[BYTE_W-1:0];

    // status byte; bit 6 carries the live master summary on a register read
    assign statusByte = {operSummary,
                         masterSummary,
                         stdSummary,
                         queueNotEmpty,
                         faultSummary,
                         3'b000};
    assign masterSummary = |({operSummary, 1'b0, stdSummary, queueNotEmpty, faultSummary, 3'b000}
                             & srqEnable);
    assign pollByte = {statusByte[BYTE_W-1], requestService, statusByte[SB_MSS_BIT-1:0]};

    // register read mux
    assign readMux = (regSelect == SEL_OPERATION_SUMMARY_COND)   ? operCondition :
                     (regSelect == SEL_OPERATION_SUMMARY_RISE)   ? operRise :
                     (regSelect == SEL_OPERATION_SUMMARY_FALL)   ? operFall :
                     (regSelect == SEL_OPERATION_SUMMARY_EVENT)  ? operEvent :
                     (regSelect == SEL_OPERATION_SUMMARY_ENABLE) ? operEnable :
                     (regSelect == SEL_FAULT_COND)  ? faultCondition :
                     (regSelect == SEL_FAULT_RISE)  ? faultRise :
                     (regSelect == SEL_FAULT_FALL)  ? faultFall :
                     (regSelect == SEL_FAULT_EVENT) ? faultEvent :
                     (regSelect == SEL_FAULT_EN)    ? faultEnable :
                     (regSelect == SEL_STD_EVENT)   ? {8'h00, stdEvent} :
                     (regSelect == SEL_STD_ENABLE)  ? {8'h00, stdEnable} :
                     (regSelect == SEL_STATUS_BYTE) ? {8'h00, statusByte} :
                     (regSelect == SEL_SRQ_ENABLE)  ? {8'h00, srqEnable} :
                     GROUP_RESET;

    // read answer registered one cycle after the strobe
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            regReadData  <= GROUP_RESET;
            regReadValid <= 1'b0;
        end
        else if (clockEnable)
        begin
            regReadValid <= regRead;
            if (regRead)
                regReadData <= readMux;
        end
    end

    // request service latches on a rising master summary; a poll returns then clears it
    logic lastMaster;
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            requestService <= 1'b0;
            lastMaster     <= 1'b0;
            pollData       <= BYTE_RESET;
            pollValid      <= 1'b0;
        end
        else if (clockEnable)
        begin
            lastMaster <= masterSummary;
            pollValid  <= serialPoll;
            if (serialPoll)
                pollData <= pollByte;
            // a new request in the poll cycle wins over the clear
            if (masterSummary && !lastMaster)
                requestService <= 1'b1;
            else if (serialPoll)
                requestService <= 1'b0;
        end
    end

    // service request line and enable mirror, both from flops
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            serviceRequest <= 1'b0;
            stdEnableOut   <= BYTE_RESET;
        end
        else if (clockEnable)
        begin
            serviceRequest <= requestService;
            stdEnableOut   <= stdEnable;
        end
    end
endmodule

/* File: verilog/transition_filter.sv */
// one status group: condition sampling, rise/fall filters, latched event and enabled summary
`timescale 1ns/1ps
module transition_filter #(
    parameter int WIDTH = 16
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic             enable,
    input  wire logic [WIDTH-1:0] condition,
    input  wire logic [WIDTH-1:0] riseFilter,
    input  wire logic [WIDTH-1:0] fallFilter,
    input  wire logic [WIDTH-1:0] enableMask,
    input  wire logic [WIDTH-1:0] extraSet,
    input  wire logic             clearRead,
    output logic      [WIDTH-1:0] eventLatch,
    output logic                  summary
);
    logic [WIDTH-1:0] lastCondition;
    logic [WIDTH-1:0] edgeHit;

    // per-bit edge detect against the previous cycle; set beats a clearing read
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        assign edgeHit[i] = (riseFilter[i] & condition[i] & ~lastCondition[i])
                          | (fallFilter[i] & ~condition[i] & lastCondition[i])
                          | extraSet[i];
        always_ff @(posedge clock or negedge resetn)
        begin
            if (!resetn)
            begin
                lastCondition[i] <= 1'b0;
                eventLatch[i]    <= 1'b0;
            end
            else if (enable)
            begin
                lastCondition[i] <= condition[i];
                eventLatch[i]    <= edgeHit[i] | (eventLatch[i] & ~clearRead);
            end
        end
    end

    // unlatched summary, so a clearing read drops it unless enabled events remain
    assign summary = |(eventLatch & enableMask);
endmodule
